// [rtl/hbd_pkg.sv]
// Purpose: Shared constants and carriers for the host bus decode block
// Assumes: 11-bit ISA I/O address, 8-bit host data, 32-bit Avalon-MM register bus
// Notes:   Module address windows are fixed legacy I/O ranges
package hbd_pkg;
  localparam int unsigned HBD_AW = 11;
  localparam int unsigned HBD_DW = 8;
  // Avalon word indexes (byte address bits 4:2)
  localparam logic [2:0] HBD_REG_FER    = 3'h0;
  localparam logic [2:0] HBD_REG_MODE   = 3'h1;
  localparam logic [2:0] HBD_REG_PTR    = 3'h2;
  localparam logic [2:0] HBD_REG_S0_1ST = 3'h3;
  localparam logic [2:0] HBD_REG_S0_2ND = 3'h4;
  localparam logic [2:0] HBD_REG_S1_1ST = 3'h5;
  localparam logic [2:0] HBD_REG_S1_2ND = 3'h6;
  localparam logic [2:0] HBD_REG_STAT   = 3'h7;
  // Host-side configuration indexes
  localparam logic [7:0] HBD_IDX_FER    = 8'h00;
  localparam logic [7:0] HBD_IDX_MODE   = 8'h01;
  localparam logic [7:0] HBD_IDX_PTR    = 8'h02;
  localparam logic [7:0] HBD_IDX_S0_1ST = 8'h0A;
  localparam logic [7:0] HBD_IDX_S0_2ND = 8'h0B;
  localparam logic [7:0] HBD_IDX_S1_1ST = 8'h0C;
  localparam logic [7:0] HBD_IDX_S1_2ND = 8'h0D;
  // Field positions
  localparam int unsigned HBD_PTR_RBE   = 2;
  localparam int unsigned HBD_MODE_AT   = 0;
  localparam int unsigned HBD_SF_AHI    = 0;
  localparam int unsigned HBD_SF_RD     = 3;
  localparam int unsigned HBD_SF_WR     = 4;
  localparam int unsigned HBD_SF_OE     = 5;
  localparam int unsigned HBD_SF_KBCOFF = 7;
  // Function enable bits
  localparam int unsigned HBD_NMOD    = 5;
  localparam int unsigned HBD_M_PAR   = 0;
  localparam int unsigned HBD_M_UART1 = 1;
  localparam int unsigned HBD_M_UART2 = 2;
  localparam int unsigned HBD_M_FDC   = 3;
  localparam int unsigned HBD_M_IDE   = 4;
  // Module windows: base and mask of ignored low bits; AT-mode excluded addresses
  localparam logic [HBD_AW-1:0] HBD_PAR_BASE   = 11'h378;
  localparam logic [HBD_AW-1:0] HBD_UART1_BASE = 11'h3F8;
  localparam logic [HBD_AW-1:0] HBD_UART2_BASE = 11'h2F8;
  localparam logic [HBD_AW-1:0] HBD_FDC_BASE   = 11'h3F0;
  localparam logic [HBD_AW-1:0] HBD_IDE_BASE   = 11'h1F0;
  localparam logic [HBD_AW-1:0] HBD_WIN_MASK   = 11'h007;
  localparam logic [HBD_AW-1:0] HBD_AT_EXCL_A  = 11'h3F7;
  localparam logic [HBD_AW-1:0] HBD_AT_EXCL_B  = 11'h377;
  // Index register base choices by base-address strap value
  localparam logic [HBD_AW-1:0] HBD_BASE0 = 11'h398;
  localparam logic [HBD_AW-1:0] HBD_BASE1 = 11'h26E;
  localparam logic [HBD_AW-1:0] HBD_BASE2 = 11'h15C;
  localparam logic [HBD_AW-1:0] HBD_BASE3 = 11'h02E;
  // Reset values and strap settling wait
  localparam logic [7:0] HBD_MODE_RST = 8'h00;
  localparam logic [7:0] HBD_PTR_RST  = 8'h04;
  localparam logic [7:0] HBD_SEL_RST  = 8'h00;
  localparam logic [1:0] HBD_STRAP_WAIT = 2'h2;

  typedef struct packed {
    logic [HBD_AW-1:0] addr;
    logic              rd;
    logic              wr;
    logic              aen;
    logic              dma;
  } hbd_host_t;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
  } hbd_sel_cfg_t;
endpackage : hbd_pkg

// [rtl/hbd_host_decode.sv]
// What this block does
// - While address enable is high no internal function or register is selected from the address.
// - DMA transfers proceed whatever the level on address enable.
// - The two base-address straps are sampled at reset and pick one of four index/data bases.
// - The five configuration straps are sampled at power-up and pick one of 32 defaults.
// - The read buffer enable is asserted for every answered host read except hard-disk reads.
// - The read buffer enable works only when bit 2 of the power and test register is one.
// - In AT mode the read buffer enable stays inactive for reads of 3F7 and 377.
// - The read buffer enable stays inactive for reads of a disabled module.
// - The keyboard select input grants access only while bit 7 of select-0 first config is zero.
// - Each programmable select is driven from an address and conditions held in configs 0Ah-0Dh.
// - A select pin used as output enable makes the input it would carry read as one.
// - Host data bit 0 is the least significant and bit 7 the most significant.
//
// Purpose: Host address decode, strap capture, buffer enable and programmable selects
// Assumes: Host pins are asynchronous and pass two flip-flops; registers over Avalon-MM
// Notes:   Host-side index/data pair: index is host-writable, data is read-only from the host
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module hbd_host_decode
  import hbd_pkg::*;
(
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              NRST,
  // Avalon-MM slave
  input  wire logic [4:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  output logic [31:0]            AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // Host bus
  input  wire logic [HBD_AW-1:0] HOST_ADDR,
  input  wire logic              HOST_IOR_N,
  input  wire logic              HOST_IOW_N,
  input  wire logic              AEN,
  input  wire logic              DMA_ACK_N,
  input  wire logic [HBD_DW-1:0] HOST_DATA_IN,
  output logic [HBD_DW-1:0]      HOST_DATA_OUT,
  output logic                   HOST_DATA_OE,
  // Straps and selects
  input  wire logic [1:0]        BASE_ADDRESS_STRAPS,
  input  wire logic [4:0]        POWER_UP_CONFIG_STRAPS,
  input  wire logic              KBC_SELECT_IN_N,
  output logic                   READ_BUFFER_ENABLE_N,
  output logic [1:0]             PROGRAMMABLE_SELECT_OUTPUTS_N,
  output logic                   KBC_ACCESS
);
  localparam int unsigned SW = HBD_AW + 4 + HBD_DW + 2 + 5 + 1;
  // Idle pin levels, so no false strobe is seen while the synchronisers refill
  localparam logic [SW-1:0] SYNC_IDLE = {{HBD_AW{1'b0}}, 4'hF, {HBD_DW{1'b0}}, 7'h00, 1'b1};

  logic [SW-1:0]         sync1_r;
  logic [SW-1:0]         sync2_r;
  hbd_host_t             hs;
  logic [HBD_DW-1:0]     data_s;
  logic [1:0]            bstrap_s;
  logic [4:0]            cfg_s;
  logic                  kbc_n_s;
  logic [HBD_NMOD-1:0]   fer_r;
  logic [7:0]            mode_r;
  logic [7:0]            ptr_r;
  hbd_sel_cfg_t          sel_r [2];
  logic [7:0]            index_r;
  logic [1:0]            base_sel_r;
  logic [4:0]            cfg_strap_r;
  logic [1:0]            strap_cnt_r;
  logic                  strap_done_r;
  logic                  wait_r;
  logic [HBD_AW-1:0]     base;
  logic                  addr_ok;
  logic [HBD_NMOD-1:0]   hit;
  logic                  cfg_idx_hit;
  logic                  cfg_dat_hit;
  logic                  at_excl;
  logic                  rbe_nxt;
  logic [7:0]            cfg_rd;
  logic                  kbc_sel_eff_n;
  logic                  av_take;

  // Two-flop synchronisers for all host pins and straps
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else begin
      sync1_r <= {HOST_ADDR, HOST_IOR_N, HOST_IOW_N, AEN, DMA_ACK_N, HOST_DATA_IN,
                  BASE_ADDRESS_STRAPS, POWER_UP_CONFIG_STRAPS, KBC_SELECT_IN_N};
      sync2_r <= sync1_r;
    end
  end

  assign hs.addr = sync2_r[SW-1 -: HBD_AW];
  assign hs.rd   = !sync2_r[SW-HBD_AW-1];
  assign hs.wr   = !sync2_r[SW-HBD_AW-2];
  assign hs.aen  = sync2_r[SW-HBD_AW-3];
  assign hs.dma  = !sync2_r[SW-HBD_AW-4];
  assign data_s  = sync2_r[15:8];
  assign bstrap_s = sync2_r[7:6];
  assign cfg_s   = sync2_r[5:1];
  assign kbc_n_s = sync2_r[0];

  function automatic logic in_win(input logic [HBD_AW-1:0] a, input logic [HBD_AW-1:0] b);
    in_win = ((a & ~HBD_WIN_MASK) == b);
  endfunction : in_win

  // Straps are captured once the synchronised value has settled after reset release
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      strap_cnt_r  <= '0;
      strap_done_r <= 1'b0;
      base_sel_r   <= '0;
      cfg_strap_r  <= '0;
    end else if (!strap_done_r) begin
      if (strap_cnt_r == HBD_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        base_sel_r   <= bstrap_s;
        cfg_strap_r  <= cfg_s;
      end else begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
    end
  end

  always_comb begin
    unique case (base_sel_r)
      2'h0:    base = HBD_BASE0;
      2'h1:    base = HBD_BASE1;
      2'h2:    base = HBD_BASE2;
      default: base = HBD_BASE3;
    endcase
  end

  // Decode
  assign addr_ok     = !hs.aen && strap_done_r;
  assign hit[HBD_M_PAR]   = in_win(hs.addr, HBD_PAR_BASE);
  assign hit[HBD_M_UART1] = in_win(hs.addr, HBD_UART1_BASE);
  assign hit[HBD_M_UART2] = in_win(hs.addr, HBD_UART2_BASE);
  assign hit[HBD_M_FDC]   = in_win(hs.addr, HBD_FDC_BASE);
  assign hit[HBD_M_IDE]   = in_win(hs.addr, HBD_IDE_BASE);
  assign cfg_idx_hit = addr_ok && (hs.addr == base);
  assign cfg_dat_hit = addr_ok && (hs.addr == HBD_AW'(base + 11'h001));
  assign at_excl     = mode_r[HBD_MODE_AT] &&
                       ((hs.addr == HBD_AT_EXCL_A) || (hs.addr == HBD_AT_EXCL_B));

  always_comb begin
    rbe_nxt = 1'b0;
    if (hs.rd && addr_ok && !hs.dma) begin
      rbe_nxt = (|(hit & fer_r) && !hit[HBD_M_IDE] && !at_excl)
                || cfg_idx_hit || cfg_dat_hit;
    end
    if (hs.rd && hs.dma && fer_r[HBD_M_FDC]) begin
      rbe_nxt = 1'b1;
    end
    rbe_nxt = rbe_nxt && ptr_r[HBD_PTR_RBE];
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      READ_BUFFER_ENABLE_N <= 1'b1;
    end else begin
      READ_BUFFER_ENABLE_N <= !rbe_nxt;
    end
  end

  // Programmable selects
  for (genvar k = 0; k < 2; k++) begin : g_sel
    logic match;
    logic cond;
    assign match = addr_ok && !hs.dma &&
                   (hs.addr == {sel_r[k].first[HBD_SF_AHI +: 3], sel_r[k].second});
    assign cond  = sel_r[k].first[HBD_SF_OE] ? hs.rd :
                   ((hs.rd && sel_r[k].first[HBD_SF_RD]) || (hs.wr && sel_r[k].first[HBD_SF_WR]));
    always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
        PROGRAMMABLE_SELECT_OUTPUTS_N[k] <= 1'b1;
      end else begin
        PROGRAMMABLE_SELECT_OUTPUTS_N[k] <= !(match && cond);
      end
    end
  end

  // Keyboard controller gate
  assign kbc_sel_eff_n = sel_r[0].first[HBD_SF_OE] ? 1'b1 : kbc_n_s;
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      KBC_ACCESS <= 1'b0;
    end else begin
      KBC_ACCESS <= !sel_r[0].first[HBD_SF_KBCOFF] && !kbc_sel_eff_n
                    && addr_ok && (hs.rd || hs.wr);
    end
  end

  // Host index/data pair
  always_comb begin
    unique case (index_r)
      HBD_IDX_FER:    cfg_rd = 8'(fer_r);
      HBD_IDX_MODE:   cfg_rd = mode_r;
      HBD_IDX_PTR:    cfg_rd = ptr_r;
      HBD_IDX_S0_1ST: cfg_rd = sel_r[0].first;
      HBD_IDX_S0_2ND: cfg_rd = sel_r[0].second;
      HBD_IDX_S1_1ST: cfg_rd = sel_r[1].first;
      HBD_IDX_S1_2ND: cfg_rd = sel_r[1].second;
      default:        cfg_rd = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      index_r <= 8'h00;
    end else if (hs.wr && cfg_idx_hit && !hs.dma) begin
      index_r <= data_s;
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      HOST_DATA_OE  <= 1'b0;
      HOST_DATA_OUT <= '0;
    end else begin
      HOST_DATA_OE  <= hs.rd && !hs.dma && (cfg_idx_hit || cfg_dat_hit);
      HOST_DATA_OUT <= cfg_idx_hit ? index_r : cfg_rd;
    end
  end

  // Avalon slave: one wait cycle, then the access completes
  assign av_take = (AVS_READ || AVS_WRITE) && !wait_r;

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wait_r          <= 1'b1;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      wait_r          <= !((AVS_READ || AVS_WRITE) && wait_r);
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && wait_r);
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      fer_r    <= '0;
      mode_r   <= HBD_MODE_RST;
      ptr_r    <= HBD_PTR_RST;
      sel_r[0] <= {HBD_SEL_RST, HBD_SEL_RST};
      sel_r[1] <= {HBD_SEL_RST, HBD_SEL_RST};
    end else if (!strap_done_r && strap_cnt_r == HBD_STRAP_WAIT) begin
      fer_r <= cfg_s;
    end else if (av_take && AVS_WRITE) begin
      unique case (AVS_ADDRESS[4:2])
        HBD_REG_FER:    fer_r           <= AVS_WRITEDATA[HBD_NMOD-1:0];
        HBD_REG_MODE:   mode_r          <= AVS_WRITEDATA[7:0];
        HBD_REG_PTR:    ptr_r           <= AVS_WRITEDATA[7:0];
        HBD_REG_S0_1ST: sel_r[0].first  <= AVS_WRITEDATA[7:0];
        HBD_REG_S0_2ND: sel_r[0].second <= AVS_WRITEDATA[7:0];
        HBD_REG_S1_1ST: sel_r[1].first  <= AVS_WRITEDATA[7:0];
        HBD_REG_S1_2ND: sel_r[1].second <= AVS_WRITEDATA[7:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      AVS_READDATA <= '0;
    end else if (AVS_READ && wait_r) begin
      unique case (AVS_ADDRESS[4:2])
        HBD_REG_FER:    AVS_READDATA <= 32'(fer_r);
        HBD_REG_MODE:   AVS_READDATA <= 32'(mode_r);
        HBD_REG_PTR:    AVS_READDATA <= 32'(ptr_r);
        HBD_REG_S0_1ST: AVS_READDATA <= 32'(sel_r[0].first);
        HBD_REG_S0_2ND: AVS_READDATA <= 32'(sel_r[0].second);
        HBD_REG_S1_1ST: AVS_READDATA <= 32'(sel_r[1].first);
        HBD_REG_S1_2ND: AVS_READDATA <= 32'(sel_r[1].second);
        default:        AVS_READDATA <= {23'h0, strap_done_r, cfg_strap_r, base_sel_r, 1'b0};
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  sequence s_dma_read;
    hs.rd && hs.dma && fer_r[HBD_M_FDC] && ptr_r[HBD_PTR_RBE];
  endsequence
  sequence s_capture;
    !strap_done_r ##1 strap_done_r;
  endsequence

  chk_aen_no_select: assert property (hs.aen |=>
      PROGRAMMABLE_SELECT_OUTPUTS_N == 2'h3 && !KBC_ACCESS && !HOST_DATA_OE)
    else $error("select raised while address enable high");
  chk_dma_ignores_aen: assert property (s_dma_read |=> !READ_BUFFER_ENABLE_N)
    else $error("DMA read did not enable read buffer");
  chk_base_strap_take: assert property (s_capture |-> base_sel_r == $past(bstrap_s))
    else $error("base strap not captured");
  chk_cfg_strap_take: assert property (s_capture |-> fer_r == $past(cfg_s)
      && cfg_strap_r == $past(cfg_s))
    else $error("config straps not captured");
  chk_ide_no_buffer: assert property (hs.rd && !hs.dma && hit[HBD_M_IDE]
      |=> READ_BUFFER_ENABLE_N)
    else $error("read buffer enabled for disk interface read");
  chk_ptr_gates_rbe: assert property (!ptr_r[HBD_PTR_RBE] |=> READ_BUFFER_ENABLE_N)
    else $error("read buffer enabled while gated off");
  chk_at_exclusion: assert property (hs.rd && !hs.dma && at_excl
      && !cfg_idx_hit && !cfg_dat_hit |=> READ_BUFFER_ENABLE_N)
    else $error("read buffer enabled for excluded address");
  chk_disabled_module: assert property (hs.rd && !hs.dma && |hit && !(|(hit & fer_r))
      && !cfg_idx_hit && !cfg_dat_hit |=> READ_BUFFER_ENABLE_N)
    else $error("read buffer enabled for disabled module");
  chk_kbc_gate: assert property (KBC_ACCESS |-> !$past(sel_r[0].first[HBD_SF_KBCOFF])
      && !$past(kbc_sel_eff_n))
    else $error("keyboard access without grant");
  chk_sel_decode: assert property (!PROGRAMMABLE_SELECT_OUTPUTS_N[0] |->
      $past(hs.addr) == $past({sel_r[0].first[2:0], sel_r[0].second}))
    else $error("select asserted on wrong address");
  chk_oe_kbc_off: assert property (sel_r[0].first[HBD_SF_OE] |=> !KBC_ACCESS)
    else $error("keyboard access while pin is output enable");
  chk_data_drive: assert property (HOST_DATA_OE |-> $past(hs.rd)
      && ($past(cfg_idx_hit) || $past(cfg_dat_hit)))
    else $error("host data driven outside own read");
  chk_avs_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
      |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");
endmodule : hbd_host_decode
`default_nettype wire

// [tb/hbd_host_model.sv]
// Purpose: Behavioural ISA host for the decode block
// Assumes: Each strobe is held 5 cycles and outputs are sampled at its last edge
// Notes:   Released data lines show the inverse of the last value driven
`timescale 1ns/10ps
`default_nettype none
module hbd_host_model
  import hbd_pkg::*;
(
  // Clock
  input  wire logic              CLOCK,
  // Host pins driven
  output var logic [HBD_AW-1:0]  HOST_ADDR,
  output var logic               HOST_IOR_N,
  output var logic               HOST_IOW_N,
  output var logic               AEN,
  output var logic               DMA_ACK_N,
  output var logic [HBD_DW-1:0]  HOST_DATA_IN,
  output var logic               KBC_SELECT_IN_N,
  // Pins observed
  input  wire logic [HBD_DW-1:0] HOST_DATA_OUT,
  input  wire logic              HOST_DATA_OE,
  input  wire logic              READ_BUFFER_ENABLE_N,
  input  wire logic [1:0]        PROGRAMMABLE_SELECT_OUTPUTS_N,
  input  wire logic              KBC_ACCESS
);
  logic [7:0] obs_data;
  logic       obs_oe;
  logic       obs_rbe_n;
  logic [1:0] obs_sel_n;
  logic       obs_kbc;

  initial begin
    HOST_ADDR = 11'h000;
    HOST_IOR_N = 1'b1;
    HOST_IOW_N = 1'b1;
    AEN = 1'b1;
    DMA_ACK_N = 1'b1;
    HOST_DATA_IN = 8'hA5;
    KBC_SELECT_IN_N = 1'b1;
  end

  // One host cycle; strobes held longer than the 4 cycle minimum
  task automatic access(input hbd_host_t req, input logic kbc_n, input logic [7:0] d);
    @(posedge CLOCK);
    HOST_ADDR <= req.addr;
    HOST_IOR_N <= ~req.rd;
    HOST_IOW_N <= ~req.wr;
    AEN <= req.aen;
    DMA_ACK_N <= ~req.dma;
    KBC_SELECT_IN_N <= kbc_n;
    HOST_DATA_IN <= req.wr ? d : ~HOST_DATA_IN;
    repeat (5) @(posedge CLOCK);
    obs_data = HOST_DATA_OUT;
    obs_oe = HOST_DATA_OE;
    obs_rbe_n = READ_BUFFER_ENABLE_N;
    obs_sel_n = PROGRAMMABLE_SELECT_OUTPUTS_N;
    obs_kbc = KBC_ACCESS;
    HOST_IOR_N <= 1'b1;
    HOST_IOW_N <= 1'b1;
    DMA_ACK_N <= 1'b1;
    AEN <= 1'b1;
    KBC_SELECT_IN_N <= 1'b1;
    HOST_DATA_IN <= ~HOST_DATA_IN;
    repeat (5) @(posedge CLOCK);
  endtask : access
endmodule : hbd_host_model
`default_nettype wire

// [tb/hbd_host_decode_tb.sv]
// Purpose: Self-checking bench for the host decode block
// Assumes: Avalon answers after one wait cycle; host outputs settle within 3 cycles
// Notes:   Random straps, function enables and addresses from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module hbd_host_decode_tb
  import hbd_pkg::*;
;
  logic CLOCK, NRST, avs_read, avs_write, AEN, IOR_N, IOW_N, DACK_N, KBC_N, OE, RBE_N, KBC;
  logic [4:0] avs_address, cfg, fer;
  logic [31:0] avs_writedata, rdata, q;
  logic AVS_WAITREQUEST;
  logic [1:0] bs, SEL_N;
  logic [10:0] HADDR, base, a;
  logic [7:0] DIN, DOUT, d8;
  logic at;
  int failures, n_checks;
  logic [10:0] win[5] = '{HBD_PAR_BASE, HBD_UART1_BASE, HBD_UART2_BASE, HBD_FDC_BASE,
                          HBD_IDE_BASE};
  logic [10:0] s_addr[6] = '{11'h201, 11'h201, 11'h310, 11'h310, 11'h201, 11'h202};
  logic [5:0] s_rwa[6] = '{6'h4, 6'h2, 6'h2, 6'h4, 6'h5, 6'h4};
  logic [1:0] s_exp[6] = '{2'b10, 2'b10, 2'b11, 2'b01, 2'b11, 2'b11};

  hbd_host_decode u_hbd_host_decode (.CLOCK(CLOCK), .NRST(NRST), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(AVS_WAITREQUEST), .HOST_ADDR(HADDR),
    .HOST_IOR_N(IOR_N), .HOST_IOW_N(IOW_N), .AEN(AEN), .DMA_ACK_N(DACK_N),
    .HOST_DATA_IN(DIN), .HOST_DATA_OUT(DOUT), .HOST_DATA_OE(OE),
    .BASE_ADDRESS_STRAPS(bs), .POWER_UP_CONFIG_STRAPS(cfg), .KBC_SELECT_IN_N(KBC_N),
    .READ_BUFFER_ENABLE_N(RBE_N), .PROGRAMMABLE_SELECT_OUTPUTS_N(SEL_N), .KBC_ACCESS(KBC));
  hbd_host_model u_hbd_host_model (.CLOCK(CLOCK), .HOST_ADDR(HADDR), .HOST_IOR_N(IOR_N),
    .HOST_IOW_N(IOW_N), .AEN(AEN), .DMA_ACK_N(DACK_N), .HOST_DATA_IN(DIN),
    .KBC_SELECT_IN_N(KBC_N), .HOST_DATA_OUT(DOUT), .HOST_DATA_OE(OE),
    .READ_BUFFER_ENABLE_N(RBE_N), .PROGRAMMABLE_SELECT_OUTPUTS_N(SEL_N), .KBC_ACCESS(KBC));

  initial begin
    CLOCK = 1'b0;
    forever #10 CLOCK = ~CLOCK;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic av(input logic wr, input logic [4:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    avs_address <= ad;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge CLOCK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 50) begin
      @(posedge CLOCK);
      n++;
    end
    if (n == 50) begin
      failures++;
      summarize();
    end
    q = rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge CLOCK);
  endtask : av

  task automatic host(input logic [10:0] ad, input logic [5:0] rwad, input logic kn,
                      input logic [7:0] d);
    u_hbd_host_model.access('{ad, rwad[2], rwad[1], rwad[0], rwad[3]}, kn, d);
  endtask : host

  function automatic logic [10:0] base_of(input logic [1:0] s);
    case (s)
      2'h0: return HBD_BASE0;
      2'h1: return HBD_BASE1;
      2'h2: return HBD_BASE2;
      default: return HBD_BASE3;
    endcase
  endfunction : base_of

  function automatic logic exp_rbe_n(input logic [10:0] ad, input logic [4:0] f, input logic m);
    logic [10:0] w;
    w = ad & ~HBD_WIN_MASK;
    if (m && (ad == HBD_AT_EXCL_A || ad == HBD_AT_EXCL_B)) return 1'b1;
    if (w == HBD_PAR_BASE) return ~f[HBD_M_PAR];
    if (w == HBD_UART1_BASE) return ~f[HBD_M_UART1];
    if (w == HBD_UART2_BASE) return ~f[HBD_M_UART2];
    if (w == HBD_FDC_BASE) return ~f[HBD_M_FDC];
    return 1'b1;
  endfunction : exp_rbe_n

  initial begin
    void'($urandom(32'h3675));
    failures = 0;
    n_checks = 0;
    NRST = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    bs = 2'($urandom);
    cfg = 5'($urandom);
    repeat (8) @(posedge CLOCK);
    check("rbe_n in reset", 1, RBE_N);
    NRST <= 1'b1;
    repeat (6) @(posedge CLOCK);
    av(0, 5'h00, 0); check("fer", {27'h0, cfg}, q);
    av(0, 5'h1C, 0); check("status", {23'h0, 1'b1, cfg, bs, 1'b0}, q);
    av(0, 5'h08, 0); check("power_test", 32'h4, q);
    $display("test reset values done");
    base = base_of(bs);
    d8 = 8'($urandom);
    av(1, 5'h18, {24'h0, d8});
    host(base, 6'h2, 1'b1, HBD_IDX_S1_2ND);
    host(base + 11'h1, 6'h4, 1'b1, 8'h00);
    check("data", d8, u_hbd_host_model.obs_data);
    check("oe", 1, u_hbd_host_model.obs_oe);
    check("rbe_n", 0, u_hbd_host_model.obs_rbe_n);
    host(base + 11'h1, 6'h5, 1'b1, 8'h00);
    check("oe aen", 0, u_hbd_host_model.obs_oe);
    check("rbe_n aen", 1, u_hbd_host_model.obs_rbe_n);
    $display("test index data done");
    for (int i = 0; i < 24; i++) begin
      fer = (i < 2) ? 5'h1F : 5'($urandom);
      at = (i < 2) ? i[0] : 1'($urandom);
      a = (i < 2) ? HBD_AT_EXCL_A : (win[$urandom % 5] | (11'($urandom) & HBD_WIN_MASK));
      av(1, 5'h00, {27'h0, fer});
      av(1, 5'h04, {31'h0, at});
      host(a, 6'h4, 1'b1, 8'h00);
      check("rbe_n mod", exp_rbe_n(a, fer, at), u_hbd_host_model.obs_rbe_n);
      check("oe mod", 0, u_hbd_host_model.obs_oe);
    end
    $display("test module reads done");
    av(1, 5'h00, 32'h1F);
    av(1, 5'h04, 0);
    av(1, 5'h08, 0);
    host(HBD_PAR_BASE, 6'h4, 1'b1, 8'h00);
    check("rbe_n off", 1, u_hbd_host_model.obs_rbe_n);
    av(1, 5'h08, 32'h4);
    host(11'h123, 6'hD, 1'b1, 8'h00);
    check("rbe_n dma", 0, u_hbd_host_model.obs_rbe_n);
    $display("test enable and dma done");
    av(1, 5'h0C, 32'h1A);
    av(1, 5'h10, 32'h01);
    av(1, 5'h14, 32'h0B);
    av(1, 5'h18, 32'h10);
    for (int i = 0; i < 6; i++) begin
      host(s_addr[i], s_rwa[i], 1'b1, 8'h3C);
      check("sel_n", s_exp[i], u_hbd_host_model.obs_sel_n);
    end
    host(11'h060, 6'h4, 1'b0, 8'h00);
    check("kbc grant", 1, u_hbd_host_model.obs_kbc);
    av(1, 5'h0C, 32'h9A);
    host(11'h060, 6'h4, 1'b0, 8'h00);
    check("kbc blocked", 0, u_hbd_host_model.obs_kbc);
    av(1, 5'h0C, 32'h3A);
    host(11'h201, 6'h4, 1'b0, 8'h00);
    check("kbc oe mode", 0, u_hbd_host_model.obs_kbc);
    check("sel_n oe mode", 2'b10, u_hbd_host_model.obs_sel_n);
    $display("test selects done");
    NRST <= 1'b0;
    bs <= 2'($urandom);
    cfg <= 5'($urandom);
    repeat (2) @(posedge CLOCK);
    NRST <= 1'b1;
    repeat (6) @(posedge CLOCK);
    av(0, 5'h1C, 0); check("status again", {23'h0, 1'b1, cfg, bs, 1'b0}, q);
    av(0, 5'h00, 0); check("fer again", {27'h0, cfg}, q);
    $display("test second reset done");
    summarize();
  end
endmodule : hbd_host_decode_tb
`default_nettype wire
